// ### hw/strap_pkg.sv
// strap capture package: register indices, field positions, decode values
// assumes a 32-bit classic wishbone slave with word-aligned registers
package strap_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] STRAP_STATUS_IDX = 16'hFF12;
    localparam logic [15:0] DECODE_IDX       = 16'hFF14;
    localparam logic [15:0] CTRL_IDX         = 16'hFF16;

    // strap_status_reg fields
    localparam int STS_SHARED_BIT = 0;
    localparam int STS_BASE0_BIT  = 1;
    localparam int STS_BASE1_BIT  = 2;

    // decode register fields
    localparam int DEC_ENV_LSB    = 0;
    localparam int DEC_XOR_BIT    = 2;
    localparam int DEC_FLOAT_BIT  = 3;
    localparam int DEC_CORE_BIT   = 4;
    localparam int DEC_SHARED_BIT = 5;
    localparam int DEC_ADDR_LSB   = 8;

    // control register fields
    localparam int CTRL_HOLD_BIT  = 0;

    // configuration index-data pair base addresses
    localparam logic [7:0] CFG_BASE_LOW  = 8'h2E;
    localparam logic [7:0] CFG_BASE_HIGH = 8'h4E;
    localparam logic [7:0] CFG_BASE_NONE = 8'h00;

    // values after reset
    localparam logic [1:0]  BASE_SEL_RESET = 2'h0;
    localparam logic [1:0]  ENV_SEL_RESET  = 2'h0;
    localparam logic        CTRL_HOLD_RST  = 1'h0;
    localparam logic [31:0] WB_DATA_RESET  = 32'h00000000;

    // base-select strap decode, written {bit1, bit0}
    typedef enum logic [1:0] {
        BASE_LOW  = 2'b00,
        BASE_HIGH = 2'b01,
        BASE_CORE = 2'b10,
        BASE_XOR  = 2'b11
    } base_sel_type;

    // environment strap decode, written {bit1, bit0}
    typedef enum logic [1:0] {
        ENV_FIRST   = 2'b00,
        ENV_SECOND  = 2'b10,
        ENV_THIRD   = 2'b01,
        ENV_INVALID = 2'b11
    } env_type;

endpackage : strap_pkg

// ### hw/xor_chain.sv
// xor chain across the observed pin levels
// assumes the pin vector is synchronous to the clock of the user
`timescale 1ns/10ps
`default_nettype none
module xor_chain #(
    parameter int WIDTH = 32
) (
    // pins under test
    input  wire logic [WIDTH-1:0] pins_i,
    // chain result
    output logic                  chain_o
);
    logic [WIDTH:0] link;

    assign link[0] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_stage
            assign link[g+1] = link[g] ^ pins_i[g];
        end
    endgenerate

    assign chain_o = link[WIDTH];
endmodule : xor_chain
`default_nettype wire

// ### hw/strap_sampling_config.sv
// strap capture and decode with a classic wishbone register slave
// assumes srst_i is the supply power-up reset, straps steady during it
`timescale 1ns/10ps
`default_nettype none

module strap_sampling_config
    import strap_pkg::*;
#(
    parameter int PIN_COUNT = 32,
    parameter int ADR_WIDTH = 18
) (
    // clock, reset, enable
    input  wire logic                 mclk_i,
    input  wire logic                 srst_i,
    input  wire logic                 ce_i,
    // strap pins
    input  wire logic [1:0]           cfg_base_select_i,
    input  wire logic [1:0]           environment_select_i,
    input  wire logic                 shared_bios_strap_i,
    input  wire logic                 float_all_strap_i,
    // pins observed by the xor chain
    input  wire logic [PIN_COUNT-1:0] tree_pins_i,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADR_WIDTH-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    output logic [31:0]               wb_dat_o,
    // decoded configuration
    output logic [7:0]                cfg_base_addr_o,
    output logic                      cfg_base_core_o,
    output logic                      xor_test_mode_o,
    output logic                      first_environment_o,
    output logic                      second_environment_o,
    output logic                      third_environment_o,
    output logic                      env_invalid_o,
    output logic                      shared_bios_en_o,
    output logic                      float_all_o,
    output logic                      xor_out_o
);

    // strap capture state
    logic [1:0] base_sel_reg;
    logic [1:0] base_sel_next;
    logic [1:0] env_sel_reg;
    logic [1:0] env_sel_next;
    logic       shared_reg;
    logic       shared_next;
    logic       float_reg;
    logic       float_next;

    // decoded output state
    logic [7:0] base_addr_reg;
    logic [7:0] base_addr_next;
    logic       core_reg;
    logic       core_next;
    logic       xor_mode_reg;
    logic       xor_mode_next;
    logic [3:0] env_onehot_reg;
    logic [3:0] env_onehot_next;
    logic       shared_en_reg;
    logic       shared_en_next;
    logic       float_all_reg;
    logic       float_all_next;
    logic       xor_out_reg;
    logic       xor_out_next;

    // bus state
    logic        ack_reg;
    logic        ack_next;
    logic        err_reg;
    logic        err_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        hold_reg;
    logic        hold_next;

    logic        chain;
    logic        req;
    logic [15:0] idx;
    logic [7:0]  status_byte;
    logic [31:0] decode_word;

    xor_chain #(
        .WIDTH (PIN_COUNT)
    ) u_chain (
        .pins_i  (tree_pins_i),
        .chain_o (chain)
    );

    // straps follow the pins while reset is held, then stay put
    always_comb begin
        base_sel_next = base_sel_reg;
        env_sel_next  = env_sel_reg;
        shared_next   = shared_reg;
        float_next    = float_reg;
        if (srst_i) begin
            base_sel_next = cfg_base_select_i;
            env_sel_next  = environment_select_i;
            shared_next   = shared_bios_strap_i;
            float_next    = float_all_strap_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            base_sel_reg <= base_sel_next;
            env_sel_reg  <= env_sel_next;
            shared_reg   <= shared_next;
            float_reg    <= float_next;
        end
    end

    // decode of the captured straps
    always_comb begin
        base_addr_next  = CFG_BASE_NONE;
        core_next       = 1'b0;
        xor_mode_next   = 1'b0;
        env_onehot_next = 4'h0;
        case (base_sel_type'(base_sel_reg))
            BASE_LOW:  base_addr_next = CFG_BASE_LOW;
            BASE_HIGH: base_addr_next = CFG_BASE_HIGH;
            BASE_CORE: core_next      = 1'b1;
            BASE_XOR:  xor_mode_next  = 1'b1;
            default:   base_addr_next = CFG_BASE_NONE;
        endcase
        case (env_type'(env_sel_reg))
            ENV_FIRST:   env_onehot_next = 4'h1;
            ENV_SECOND:  env_onehot_next = 4'h2;
            ENV_THIRD:   env_onehot_next = 4'h4;
            ENV_INVALID: env_onehot_next = 4'h8;
            default:     env_onehot_next = 4'h8;
        endcase
        shared_en_next = shared_reg;
        // float needs the strap, no xor test and the first or second environment
        float_all_next = float_reg && !xor_mode_next
                         && (env_onehot_next[0] || env_onehot_next[1]);
        xor_out_next = xor_out_reg;
        if (!xor_mode_next) begin
            xor_out_next = 1'b0;
        end else if (!hold_reg) begin
            xor_out_next = chain;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            base_addr_reg  <= CFG_BASE_NONE;
            core_reg       <= 1'b0;
            xor_mode_reg   <= 1'b0;
            env_onehot_reg <= 4'h0;
            shared_en_reg  <= 1'b0;
            float_all_reg  <= 1'b0;
            xor_out_reg    <= 1'b0;
        end else if (ce_i) begin
            base_addr_reg  <= base_addr_next;
            core_reg       <= core_next;
            xor_mode_reg   <= xor_mode_next;
            env_onehot_reg <= env_onehot_next;
            shared_en_reg  <= shared_en_next;
            float_all_reg  <= float_all_next;
            xor_out_reg    <= xor_out_next;
        end
    end

    // register images
    assign idx = wb_adr_i[ADR_WIDTH-1:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;

    always_comb begin
        status_byte                 = 8'h00;
        status_byte[STS_SHARED_BIT] = shared_reg;
        status_byte[STS_BASE0_BIT]  = base_sel_reg[0];
        status_byte[STS_BASE1_BIT]  = base_sel_reg[1];
    end

    always_comb begin
        decode_word                          = 32'h00000000;
        decode_word[DEC_ENV_LSB +: 2]        = env_sel_reg;
        decode_word[DEC_XOR_BIT]             = xor_mode_reg;
        decode_word[DEC_FLOAT_BIT]           = float_all_reg;
        decode_word[DEC_CORE_BIT]            = core_reg;
        decode_word[DEC_SHARED_BIT]          = shared_en_reg;
        decode_word[DEC_ADDR_LSB +: 8]       = base_addr_reg;
    end

    // one ack or err per request, answered one cycle after it appears
    always_comb begin
        ack_next   = 1'b0;
        err_next   = 1'b0;
        rdata_next = rdata_reg;
        hold_next  = hold_reg;
        if (req) begin
            rdata_next = WB_DATA_RESET;
            case (idx)
                STRAP_STATUS_IDX: begin
                    ack_next   = 1'b1;
                    rdata_next = {24'h000000, status_byte};
                end
                DECODE_IDX: begin
                    ack_next   = 1'b1;
                    rdata_next = decode_word;
                end
                CTRL_IDX: begin
                    ack_next = 1'b1;
                    rdata_next[CTRL_HOLD_BIT] = hold_reg;
                    if (wb_we_i && wb_sel_i[0]) begin
                        hold_next = wb_dat_i[CTRL_HOLD_BIT];
                    end
                end
                default: err_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= WB_DATA_RESET;
            hold_reg  <= CTRL_HOLD_RST;
        end else if (ce_i) begin
            ack_reg   <= ack_next;
            err_reg   <= err_next;
            rdata_reg <= rdata_next;
            hold_reg  <= hold_next;
        end
    end

    assign wb_ack_o             = ack_reg;
    assign wb_err_o             = err_reg;
    assign wb_dat_o             = rdata_reg;
    assign cfg_base_addr_o      = base_addr_reg;
    assign cfg_base_core_o      = core_reg;
    assign xor_test_mode_o      = xor_mode_reg;
    assign first_environment_o  = env_onehot_reg[0];
    assign second_environment_o = env_onehot_reg[1];
    assign third_environment_o  = env_onehot_reg[2];
    assign env_invalid_o        = env_onehot_reg[3];
    assign shared_bios_en_o     = shared_en_reg;
    assign float_all_o          = float_all_reg;
    assign xor_out_o            = xor_out_reg;

    // checks on the decoded outputs, the latched straps and the status read
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    AST_BASE_LOW: assert property (
        ce_i && $past(ce_i) && base_sel_reg == 2'b00
        |=> cfg_base_addr_o == CFG_BASE_LOW)
        else $error("base select 00 did not give the low pair");

    AST_BASE_HIGH: assert property (
        ce_i && base_sel_reg == 2'b01 |=> cfg_base_addr_o == CFG_BASE_HIGH)
        else $error("base select 01 did not give the high pair");

    AST_XOR_MODE: assert property (
        ce_i && base_sel_reg == 2'b11
        |=> xor_test_mode_o && cfg_base_addr_o == CFG_BASE_NONE)
        else $error("both base straps high did not enter xor test");

    AST_ENV_ONEHOT: assert property (
        ce_i && $past(ce_i)
        |=> $onehot({first_environment_o, second_environment_o,
                     third_environment_o, env_invalid_o}))
        else $error("environment outputs not one-hot");

    AST_ENV_SECOND: assert property (
        ce_i && env_sel_reg == 2'b10 |=> second_environment_o)
        else $error("encoding 10 did not pick the second environment");

    AST_SHARED: assert property (
        ce_i |=> shared_bios_en_o == $past(shared_reg))
        else $error("shared bios enable does not follow its strap");

    AST_FLOAT_ENV: assert property (
        float_all_o |-> (first_environment_o || second_environment_o))
        else $error("float active outside first or second environment");

    AST_XOR_IDLE: assert property (
        !xor_test_mode_o |-> !xor_out_o)
        else $error("tree output active outside xor test");

    AST_STRAP_FROZEN: assert property (
        !srst_i && $past(!srst_i) |-> $stable(base_sel_reg)
        && $stable(env_sel_reg) && $stable(shared_reg))
        else $error("latched strap changed after reset");

    AST_STATUS_READ: assert property (
        req && ce_i && idx == STRAP_STATUS_IDX
        |=> wb_ack_o && wb_dat_o[31:3] == 29'h0
        && wb_dat_o[2:0] == {base_sel_reg, shared_reg})
        else $error("status read returned wrong bits");

    COV_XOR: cover property (xor_test_mode_o && xor_out_o);
    COV_FLOAT: cover property (float_all_o);
    COV_READ: cover property (wb_ack_o && !wb_err_o);
    COV_ERR: cover property (wb_err_o);

endmodule : strap_sampling_config
`default_nettype wire

// ### testbench/strap_sampling_config_bench.sv
// self-checking bench for the strap capture block: every strap combination
// assumes the design package and the block's sources are compiled first
`timescale 1ns/10ps
`default_nettype none
module strap_sampling_config_bench;
    import strap_pkg::*;

    logic        mclk_i;
    logic        srst_i;
    logic        ce;
    logic [1:0]  base_s;
    logic [1:0]  env_s;
    logic        shared_s;
    logic        float_s;
    logic [31:0] tree_pins;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [17:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic        wb_ack;
    logic        wb_err;
    logic [31:0] wb_rdat;
    logic [7:0]  base_addr;
    logic        core_o, xor_mode, env1, env2, env3, env_bad, sh_o, fl_o;
    logic        xor_out;
    int          mismatches;
    int          num_checks;

    strap_sampling_config u_strap_sampling_config (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce),
        .cfg_base_select_i(base_s), .environment_select_i(env_s),
        .shared_bios_strap_i(shared_s), .float_all_strap_i(float_s),
        .tree_pins_i(tree_pins), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_ack_o(wb_ack), .wb_err_o(wb_err),
        .wb_dat_o(wb_rdat), .cfg_base_addr_o(base_addr),
        .cfg_base_core_o(core_o), .xor_test_mode_o(xor_mode),
        .first_environment_o(env1), .second_environment_o(env2),
        .third_environment_o(env3), .env_invalid_o(env_bad),
        .shared_bios_en_o(sh_o), .float_all_o(fl_o), .xor_out_o(xor_out));

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check_val

    // decoded outputs as one vector, {base, core, xor, env one-hot, sh, fl}
    function automatic logic [15:0] exp_out(input logic [1:0] b, e,
                                            input logic sh, fl);
        logic [7:0] a;
        logic       fe;
        a  = (b == 2'h0) ? CFG_BASE_LOW : (b == 2'h1) ? CFG_BASE_HIGH
                                                       : CFG_BASE_NONE;
        fe = fl & ((e == 2'h0) | (e == 2'h2)) & (b != 2'h3);
        return {a, b == 2'h2, b == 2'h3, e == 2'h0, e == 2'h2, e == 2'h1,
                e == 2'h3, sh, fe};
    endfunction : exp_out

    function automatic logic [31:0] exp_decode(input logic [1:0] b, e,
                                               input logic sh, fl);
        logic [15:0] o;
        o = exp_out(b, e, sh, fl);
        return {16'h0000, o[15:8], 2'h0, sh, o[7], o[0], o[6], e};
    endfunction : exp_decode

    // one classic cycle; waits for ack or err, takes data at that edge
    task automatic wb_xfer(input logic we, input logic [17:0] adr,
                           input logic [31:0] d, output logic [31:0] q,
                           output logic e);
        @(posedge mclk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_wdat <= d;
        wb_sel  <= 4'hF;
        do begin
            @(posedge mclk_i);
        end while (!(wb_ack === 1'b1 || wb_err === 1'b1));
        q = wb_rdat;
        e = wb_err;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        // the answer stands for one cycle only
        @(negedge mclk_i);
        check_val({30'h0, wb_ack, wb_err}, 32'h0);
    endtask : wb_xfer

    function automatic logic [15:0] seen_out();
        return {base_addr, core_o, xor_mode, env1, env2, env3, env_bad,
                sh_o, fl_o};
    endfunction : seen_out

    initial begin
        repeat (20000) @(posedge mclk_i);
        mismatches++;
        print_verdict();
    end

    initial begin
        logic [1:0]  b, e;
        logic        sh, fl, err;
        logic [31:0] q, r, last;
        srst_i = 1'b1; base_s = 2'h0; env_s = 2'h0; shared_s = 1'b0;
        float_s = 1'b0; tree_pins = 32'h0; wb_cyc = 1'b0; wb_stb = 1'b0;
        wb_we = 1'b0; wb_adr = 18'h0; wb_sel = 4'h0; wb_wdat = 32'h0;
        mismatches = 0;
        num_checks = 0;
        ce = 1'b1;
        void'($urandom(94));
        for (int k = 0; k < 64; k++) begin
            {fl, sh, e, b} = k[5:0];
            @(posedge mclk_i);
            srst_i <= 1'b1;
            base_s <= b; env_s <= e; shared_s <= sh; float_s <= fl;
            tree_pins <= $urandom();
            repeat (3) @(posedge mclk_i);
            srst_i <= 1'b0;
            repeat (2) @(posedge mclk_i);
            @(negedge mclk_i);
            check_val(seen_out(), exp_out(b, e, sh, fl));
            @(posedge mclk_i);
            {float_s, shared_s, env_s, base_s} <= 6'(~k[5:0] ^ $urandom());
            repeat (3) @(posedge mclk_i);
            @(negedge mclk_i);
            check_val(seen_out(), exp_out(b, e, sh, fl));
            wb_xfer(1'b0, {STRAP_STATUS_IDX, 2'b00}, 32'h0, q, err);
            check_val(q, {29'h0, b[1], b[0], sh});
            wb_xfer(1'b1, {STRAP_STATUS_IDX, 2'b00}, 32'hFFFFFFFF, q, err);
            check_val(err, 1'b0);
            wb_xfer(1'b0, {STRAP_STATUS_IDX, 2'b00}, 32'h0, q, err);
            check_val(q, {29'h0, b[1], b[0], sh});
            wb_xfer(1'b0, {DECODE_IDX, 2'b00}, 32'h0, q, err);
            check_val(q, exp_decode(b, e, sh, fl));
            wb_xfer(1'b0, {16'hFF20, 2'b00}, 32'h0, q, err);
            check_val(err, 1'b1);
            check_val(q, 32'h0);
            last = 32'h0;
            for (int i = 0; i < 6; i++) begin
                r = $urandom();
                if (i == 0) r = 32'h0;
                if (i == 1) r = 32'hFFFFFFFF;
                @(posedge mclk_i);
                tree_pins <= r;
                @(posedge mclk_i);
                @(negedge mclk_i);
                check_val(xor_out, (b == 2'h3) ? ^r : 1'b0);
                last = r;
            end
            if (b == 2'h3) begin
                wb_xfer(1'b1, {CTRL_IDX, 2'b00}, 32'h1, q, err);
                @(posedge mclk_i);
                tree_pins <= last ^ 32'h1;
                repeat (2) @(posedge mclk_i);
                @(negedge mclk_i);
                check_val(xor_out, ^last);
                wb_xfer(1'b1, {CTRL_IDX, 2'b00}, 32'h0, q, err);
                repeat (2) @(posedge mclk_i);
                @(negedge mclk_i);
                check_val(xor_out, ~^last);
                // clock enable low freezes the tree output
                @(posedge mclk_i);
                ce <= 1'b0;
                tree_pins <= last;
                repeat (2) @(posedge mclk_i);
                @(negedge mclk_i);
                check_val(xor_out, ~^last);
                @(posedge mclk_i);
                ce <= 1'b1;
                @(posedge mclk_i);
                @(negedge mclk_i);
                check_val(xor_out, ^last);
            end
        end
        print_verdict();
    end
endmodule : strap_sampling_config_bench
`default_nettype wire
